//--- fifo_port_flags.sv
// Write and read port control with full/ready and empty/ready flags.
// Assumes one clock mclk; write and read clients both use it, with
// per-port clock-active inputs standing for stopped clocks.
//
// Contract
// - Write stores word when enabled, not full
// - Write enable high stores nothing
// - Idle port clock holds its flags
// - Write side sets half-full, read clears
// - Standard full flag low when full, blocks
// - Fall-through input-ready high when full, blocks
// - Write enable ignored while full
// - Read moves next word to output
// - Read enable high holds output register except on fall-through load
// - Standard mode needs read enable each word
// - First word falls through on third edge
// - Output-ready low as first word appears
// - Output-ready high only on true read
// - Output-ready high blocks further reads
// - Serial offset bit shifted per write edge
// - Serial enable high keeps offsets
// - Output enable low drives data, else released
// - Load at reset picks defaults, method
// - Load low programs offsets in serial mode only
// - Standard full after depth writes
// - Fall-through full after depth plus one
// - Flags pass two or three register stages
// - Mode pin at reset picks timing mode
// - Reset clears pointers, output, flags
`timescale 1ns/1ps
`default_nettype none
module fifo_port_flags
  import fifo_port_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic writeClockActive,
  input wire logic readClockActive,
  input wire logic writeEnable_n,
  input wire logic [DATA_WIDTH-1:0] dataIn,
  input wire logic readEnable_n,
  input wire logic outputEnable_n,
  input wire logic offset_load_n,
  input wire logic serial_prog_enable,
  input wire logic mode_select_serial_in,
  output logic [DATA_WIDTH-1:0] data_out,
  output logic dataOutEnable,
  output logic full_or_input_ready,
  output logic empty_or_output_ready,
  output logic half_full_flag,
  output logic fall_through_mode,
  output logic serialMode,
  output logic [OFFSET_WIDTH-1:0] emptyOffset,
  output logic [OFFSET_WIDTH-1:0] fullOffset
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int LW = $clog2(DEPTH) + 1;
  logic strapDone_reg;                      // Straps captured after reset
  logic fall_through_mode_reg;                           // Fall-through mode selected
  logic serial_reg;                         // Serial programming selected
  logic [OFFSET_WIDTH-1:0] emptyOff_reg;    // Almost-empty offset
  logic [OFFSET_WIDTH-1:0] fullOff_reg;     // Almost-full offset
  logic [DATA_WIDTH-1:0] outWord_reg;       // Output register
  logic outHeld_reg;                        // Output register holds unread word
  logic [FULL_STAGES-1:0] fullPipe_reg;     // Full flag stages
  logic [READY_STAGES-1:0] emptyPipe_reg;   // Empty/ready stages
  logic dataOutEn_reg;                      // Data driver enable
  logic [DATA_WIDTH-1:0] dataOut_reg;       // Driven data
  logic bufInValid;
  logic bufInReady;
  logic bufOutValid;
  logic bufOutReady;
  logic [DATA_WIDTH-1:0] bufOutData;
  logic [LW-1:0] bufLevel;
  logic doWrite;
  logic stdRead;
  logic ftLoad;
  logic fullNow;
  logic emptyNow;
  logic [LW:0] stored;

  // Total word count, including a held fall-through word
  function automatic logic [LW:0] totalWords(input logic [LW-1:0] lvl, input logic held);
    totalWords = {1'b0, lvl} + {{LW{1'b0}}, held};
  endfunction

  // ----------------------------------------
  // Storage array
  // ----------------------------------------
  sync_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(DEPTH)) sync_fifo_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData(dataIn),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData),
    .level(bufLevel)
  );

  // Write only when enabled, clock running and space left
  assign doWrite = writeClockActive && !writeEnable_n && bufInReady && strapDone_reg;
  assign bufInValid = doWrite;
  // Standard read: enable low, read clock running, words present
  assign stdRead = !fall_through_mode_reg && readClockActive && !readEnable_n && bufOutValid;
  // Fall-through load: output empty, or true read of the held word
  // Waits for the second ready stage so the first word lands on the third read edge
  assign ftLoad = fall_through_mode_reg && readClockActive && bufOutValid && emptyPipe_reg[READY_STAGES-2]
                  && (!outHeld_reg || !readEnable_n);
  assign bufOutReady = stdRead || ftLoad;
  assign stored = totalWords(bufLevel, fall_through_mode_reg && outHeld_reg);
  assign fullNow = !bufInReady;
  assign emptyNow = fall_through_mode_reg ? !(bufOutValid || outHeld_reg) : !bufOutValid;

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  // Mode and load straps sampled on first edge after reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strapDone_reg <= 1'b0;
      fall_through_mode_reg <= 1'b0;
      serial_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      strapDone_reg <= 1'b1;
      fall_through_mode_reg <= mode_select_serial_in;
      serial_reg <= offset_load_n;
    end
  end

  // ----------------------------------------
  // Offset registers
  // ----------------------------------------
  // Defaults at strap time, then serial shift when selected
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      emptyOff_reg <= OFFSET_DEFAULT_PAR;
      fullOff_reg <= OFFSET_DEFAULT_PAR;
    end else if (!strapDone_reg) begin
      // Load high picks the larger default
      emptyOff_reg <= offset_load_n ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR;
      fullOff_reg <= offset_load_n ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR;
    end else if (serial_reg && writeClockActive && !offset_load_n && !serial_prog_enable) begin
      // One bit per write edge, empty offset then full offset
      emptyOff_reg <= {fullOff_reg[0], emptyOff_reg[OFFSET_WIDTH-1:1]};
      fullOff_reg <= {mode_select_serial_in, fullOff_reg[OFFSET_WIDTH-1:1]};
    end
    // Serial enable high leaves both offsets unchanged
  end

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  // Loads on standard read or fall-through load, else holds
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      outWord_reg <= DATA_RESET;
      outHeld_reg <= 1'b0;
    end else if (bufOutReady) begin
      outWord_reg <= bufOutData;
      outHeld_reg <= fall_through_mode_reg;
    end else if (fall_through_mode_reg && readClockActive && !readEnable_n && outHeld_reg) begin
      // True read of last word: word stays, marked consumed
      outHeld_reg <= 1'b0;
    end
    // Enable high, no fall-through load: register keeps its word
  end

  // ----------------------------------------
  // Full / input-ready flag
  // ----------------------------------------
  // Two stages on write side; idle write clock holds the flag
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fullPipe_reg <= '0;
    end else if (writeClockActive) begin
      fullPipe_reg <= {fullPipe_reg[FULL_STAGES-2:0], fullNow};
    end
  end

  // ----------------------------------------
  // Empty / output-ready flag
  // ----------------------------------------
  // Not-empty shifts in; standard flag uses stage two, fall-through load waits on stage two
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      emptyPipe_reg <= '0;
    end else if (readClockActive) begin
      emptyPipe_reg <= {emptyPipe_reg[READY_STAGES-2:0], !emptyNow};
    end
  end

  // ----------------------------------------
  // Half-full flag
  // ----------------------------------------
  // Write side may set it low, read side may only release it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      half_full_flag <= 1'b1;
    end else if (writeClockActive && stored > (LW+1)'(DEPTH / 2)) begin
      half_full_flag <= 1'b0;
    end else if (readClockActive && stored <= (LW+1)'(DEPTH / 2)) begin
      half_full_flag <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Data bus driver, released while output enable is high
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut_reg <= DATA_RESET;
      dataOutEn_reg <= 1'b0;
    end else begin
      dataOutEn_reg <= !outputEnable_n;
      dataOut_reg <= bufOutReady ? bufOutData : outWord_reg;
    end
  end

  // Flag pins from flops; polarity follows the mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      full_or_input_ready <= 1'b1;
      empty_or_output_ready <= 1'b0;
    end else begin
      // Each pin moves only on an edge of its own port clock
      if (writeClockActive) begin
        full_or_input_ready <= fall_through_mode_reg ? fullPipe_reg[FULL_STAGES-1]
                                        : !fullPipe_reg[FULL_STAGES-1];
      end
      if (readClockActive) begin
        empty_or_output_ready <= fall_through_mode_reg ? !(outHeld_reg || ftLoad)
                                          : emptyPipe_reg[EMPTY_STAGES-1];
      end
    end
  end

  // Status copies out of flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fall_through_mode <= 1'b0;
      serialMode <= 1'b0;
      emptyOffset <= OFFSET_DEFAULT_PAR;
      fullOffset <= OFFSET_DEFAULT_PAR;
    end else begin
      fall_through_mode <= fall_through_mode_reg;
      serialMode <= serial_reg;
      emptyOffset <= emptyOff_reg;
      fullOffset <= fullOff_reg;
    end
  end

  assign data_out = dataOut_reg;
  assign dataOutEnable = dataOutEn_reg;
endmodule
`default_nettype wire

//--- fifo_port_flags_monitor.sv
// Concurrent checks on the pins of the FIFO port flag block.
// Assumes one mclk domain and the active-low reset_n.
`timescale 1ns/1ps
`default_nettype none
module fifo_port_flags_monitor
  import fifo_port_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic writeClockActive,
  input wire logic readClockActive,
  input wire logic readEnable_n,
  input wire logic outputEnable_n,
  input wire logic offset_load_n,
  input wire logic serial_prog_enable,
  input wire logic mode_select_serial_in,
  input wire logic [DATA_WIDTH-1:0] data_out,
  input wire logic dataOutEnable,
  input wire logic full_or_input_ready,
  input wire logic empty_or_output_ready,
  input wire logic half_full_flag,
  input wire logic fall_through_mode,
  input wire logic serialMode,
  input wire logic [OFFSET_WIDTH-1:0] emptyOffset,
  input wire logic [OFFSET_WIDTH-1:0] fullOffset
);
  // Low bit of the full offset, feeding the empty offset when shifting
  logic fullLsb;
  assign fullLsb = fullOffset[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  oe_follow_a: assert property ($past(reset_n) |-> dataOutEnable == !$past(outputEnable_n))
    else $error("output drive enable wrong");
  hold_out_a: assert property (!fall_through_mode && readEnable_n |=> $stable(data_out))
    else $error("data out moved without read");
  wr_freeze_a: assert property ($past(reset_n) && !writeClockActive |=>
    $stable(full_or_input_ready)) else $error("full flag moved while write idle");
  rd_freeze_a: assert property ($past(reset_n) && !readClockActive |=>
    $stable(empty_or_output_ready)) else $error("empty flag moved while read idle");
  hf_set_a: assert property ($fell(half_full_flag) |-> $past(writeClockActive))
    else $error("half full set without write clock");
  hf_clear_a: assert property ($rose(half_full_flag) |-> $past(readClockActive))
    else $error("half full cleared without read clock");
  shift_in_a: assert property (serialMode && !serial_prog_enable && !offset_load_n
    && writeClockActive |-> ##2 fullOffset[OFFSET_WIDTH-1] == $past(mode_select_serial_in, 2)
    && emptyOffset[OFFSET_WIDTH-1] == $past(fullLsb)) else $error("serial shift wrong");
  sen_hold_a: assert property (serialMode && serial_prog_enable |-> ##2
    ($stable(fullOffset) && $stable(emptyOffset))) else $error("offsets moved");
  strap_cap_a: assert property ($rose(reset_n) |-> ##2 serialMode == $past(offset_load_n, 2)
    && fall_through_mode == $past(mode_select_serial_in, 2)) else $error("strap capture wrong");
  default_off_a: assert property ($rose(reset_n) ##1 serial_prog_enable |=>
    fullOffset == (serialMode ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR))
    else $error("default offset wrong");
  // Main scenarios reached
  cover property (!fall_through_mode && !full_or_input_ready);
  cover property (fall_through_mode && $fell(empty_or_output_ready));
  cover property (serialMode && !serial_prog_enable && !offset_load_n);
endmodule
bind fifo_port_flags fifo_port_flags_monitor #(.DEPTH(DEPTH)) fifo_port_flags_monitor_inst (.*);
`default_nettype wire

//--- fifo_port_flags_tb_top.sv
// Self-checking bench for the FIFO port flag block.
// Assumes the package constants and a 100 MHz mclk.
`timescale 1ns/1ps
`default_nettype none
module fifo_port_flags_tb_top
  import fifo_port_pkg::*;
();
  localparam logic [19:0] PAT = 20'h9_C3A5; // Serial offset pattern
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic writeClockActive = 1'b1;
  logic readClockActive = 1'b1;
  logic writeEnable_n = 1'b1;
  logic [DATA_WIDTH-1:0] dataIn = 9'h000;
  logic outputEnable_n = 1'b0;
  logic offset_load_n = 1'b0;
  logic serial_prog_enable = 1'b1;
  logic mode_select_serial_in = 1'b0;
  logic slow = 1'b1;
  logic [5:0] total = 6'h00;
  logic readEnable_n, dataOutEnable, full_or_input_ready, empty_or_output_ready;
  logic half_full_flag, fall_through_mode, serialMode, gotValid;
  logic [DATA_WIDTH-1:0] data_out, gotWord;
  logic [OFFSET_WIDTH-1:0] emptyOffset, fullOffset;
  int mismatches = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  fifo_port_flags fifo_port_flags_inst (.*);
  fifo_read_host fifo_read_host_inst (.*);
  // Compare and count
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic test_done();
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Back-to-back writes of n words from base
  task automatic wrBurst(input int n, input logic [8:0] base);
    writeEnable_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      dataIn = base + 9'(i);
      cyc(1);
    end
    writeEnable_n = 1'b1;
  endtask
  // Reset with straps, then check reset and strap results
  task automatic doReset(input logic ft, input logic ld);
    reset_n = 1'b0;
    mode_select_serial_in = ft;
    offset_load_n = ld;
    cyc(4);
    chk(10'({data_out, full_or_input_ready, empty_or_output_ready, half_full_flag}), 10'h005);
    reset_n = 1'b1;
    cyc(2);
    offset_load_n = 1'b1;
    chk(10'({fall_through_mode, serialMode}), 10'({ft, ld}));
    chk(fullOffset, ld ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR);
    chk(emptyOffset, ld ? OFFSET_DEFAULT_SER : OFFSET_DEFAULT_PAR);
  endtask
  initial begin
    // Standard mode: fill past full, then drain slowly
    doReset(1'b0, 1'b0);
    wrBurst(BUF_DEPTH + 1, 9'h100);
    cyc(4);
    chk(10'(full_or_input_ready), 10'h000);
    chk(10'(half_full_flag), 10'h000);
    chk(10'(empty_or_output_ready), 10'h001);
    writeClockActive = 1'b0;
    total = 6'(BUF_DEPTH);
    for (int i = 0; i < BUF_DEPTH; i++) begin
      for (int k = 0; k < 20 && gotValid !== 1'b1; k++) cyc(1);
      chk(10'(gotWord), 10'(9'h100 + 9'(i)));
      if (i == 4) begin
        chk(10'(full_or_input_ready), 10'h000);
        writeClockActive = 1'b1;
      end
      cyc(1);
    end
    cyc(6);
    chk(10'({full_or_input_ready, empty_or_output_ready, half_full_flag}), 10'h005);
    chk(10'(data_out), 10'h11F);
    // Fall-through mode with serial offsets
    total = 6'h00;
    doReset(1'b1, 1'b1);
    readClockActive = 1'b0;
    wrBurst(2, 9'h0A5);
    cyc(6);
    chk(10'(data_out), 10'h000);
    readClockActive = 1'b1;
    cyc(2);
    chk(10'(data_out), 10'h000);
    cyc(2);
    chk(10'(data_out), 10'h0A5);
    chk(10'(empty_or_output_ready), 10'h000);
    offset_load_n = 1'b0;
    serial_prog_enable = 1'b0;
    for (int i = 0; i < 20; i++) begin
      mode_select_serial_in = PAT[i];
      cyc(1);
    end
    serial_prog_enable = 1'b1;
    offset_load_n = 1'b1;
    cyc(3);
    chk(fullOffset, PAT[19:10]);
    chk(emptyOffset, PAT[9:0]);
    chk(10'(data_out), 10'h0A5);
    // Output drive enable both ways
    outputEnable_n = 1'b1;
    cyc(2);
    chk(10'(dataOutEnable), 10'h000);
    outputEnable_n = 1'b0;
    cyc(2);
    chk(10'(dataOutEnable), 10'h001);
    test_done();
  end
  // Watchdog: the tests need about 160 cycles
  initial begin
    #20000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire

//--- fifo_port_pkg.sv
// Shared constants for the dual-port FIFO flag block.
// Assumes a single clock domain; both ports run on mclk.
package fifo_port_pkg;
  // ----------------------------------------
  // Widths and offsets
  // ----------------------------------------
  localparam int DATA_WIDTH = 9;
  localparam int OFFSET_WIDTH = 10;
  localparam int BUF_DEPTH = 32;
  localparam logic [OFFSET_WIDTH-1:0] OFFSET_DEFAULT_PAR = 10'h07F;
  localparam logic [OFFSET_WIDTH-1:0] OFFSET_DEFAULT_SER = 10'h3FF;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 9'h000;
  // ----------------------------------------
  // Flag stage counts
  // ----------------------------------------
  localparam int FULL_STAGES = 2;
  localparam int EMPTY_STAGES = 2;
  localparam int READY_STAGES = 3;
endpackage

//--- fifo_read_host.sv
// Reading client model for the FIFO port flag block, standard mode.
// Assumes mclk shared with the block and the active-low reset_n.
`timescale 1ns/1ps
`default_nettype none
module fifo_read_host
  import fifo_port_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [5:0] total,
  input wire logic slow,
  input wire logic empty_or_output_ready,
  input wire logic [DATA_WIDTH-1:0] data_out,
  output logic readEnable_n,
  output logic gotValid,
  output logic [DATA_WIDTH-1:0] gotWord
);
  logic phase_reg; // Toggles to stall every other slot
  logic taken_reg; // Read accepted on the last edge
  logic [5:0] issued_reg; // Reads handed out so far
  // One-cycle read requests while data is flagged and reads remain
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 1'b0;
      taken_reg <= 1'b0;
      issued_reg <= 6'h00;
      readEnable_n <= 1'b1;
      gotValid <= 1'b0;
      gotWord <= '0;
    end else begin
      phase_reg <= !phase_reg;
      taken_reg <= !readEnable_n && empty_or_output_ready;
      gotValid <= taken_reg;
      gotWord <= data_out;
      readEnable_n <= 1'b1;
      if (total == 6'h00) begin
        issued_reg <= 6'h00;
      end else if (readEnable_n && empty_or_output_ready && issued_reg < total
          && !(slow && phase_reg)) begin
        readEnable_n <= 1'b0;
        issued_reg <= issued_reg + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- sync_fifo.sv
// Parameterised valid/ready FIFO used as the storage array.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // Word storage
  logic [AW-1:0] wrPtr_reg;           // Next write slot
  logic [AW-1:0] rdPtr_reg;           // Next read slot
  logic [AW:0] count_reg;             // Words held
  logic doWrite;
  logic doRead;

  assign inReady = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign outValid = (count_reg != '0);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr_reg];
  assign level = count_reg;

  // Memory write
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointer and count update
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
